// ---- isp_fifo.sv ----
// synchronous valid/ready fifo for the answer character stream
// assumes writer and reader share mclk
`timescale 1ns/10ps
module isp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,    // system clock
   input  wire logic             rst_n,   // async reset, low
   input  wire logic [WIDTH-1:0] in_data, // write data
   input  wire logic             in_valid,// write request
   output logic                  in_ready,// not full
   output logic      [WIDTH-1:0] out_data,// head word
   output logic                  out_valid,// not empty
   input  wire logic             out_ready // head taken
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             do_wr;
   logic             do_rd;

   // handshakes
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // storage
   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule : isp_fifo

// ---- isp_hex_record_interpreter.sv ----
// hex record programming interpreter with autobaud serial link
// assumes an external memory port with one-cycle write and read data
// What this block does
// R1: security bit 7 low skips the two-wire ack test at boot.
// R2: security bit 6 low skips the serial receive test at boot.
// R3: low override pins cancel the two-wire and serial bypasses.
// R4: security byte copied from security_config_byte_in while idle, value unchecked.
// R5: 8 data bits, no parity, one stop bit.
// R6: first character U sets the bit time.
// R7: each record starts with a colon.
// R8: length is 40h, data field 64 bytes.
// R9: load offset is the 16-bit start of program data.
// R10: each byte travels as two ASCII hex digits.
// R11: bytes from length through checksum sum to zero.
// R12: type 00h programs 64 bytes; 01h ends the file.
// R13: type 03h erases, sets level one or two, or jumps.
// R14: type 04h displays data or code RAM, or blank checks.
// R15: type 05h reads security byte or loader version.
// R16: type 06h baud loading is refused.
// R17: checksum mismatch answers X.
// R18: bad code RAM CRC drives error code and answers Z.
// R19: bad image CRC blocks application start after any reset.
// R20: 04h display and blank check refused at security level two.
// R21: programming refused at security level one.
// R22: host reprograms 0000h to 3FFFh with 64-byte records.
// R23: FF allows all, FE blocks write, FC blocks both.
// R24: within a 03h record the level only rises and full chip erase clears it; idle reloads it from security_config_byte_in.
// R25: unknown record types are dropped with no side effects.
`timescale 1ns/10ps
module isp_hex_record_interpreter #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        mclk,            // system clock
   input  wire logic        rst_n,           // async reset, low
   input  wire logic        rxd,             // serial in (pin)
   output logic             txd,             // serial out
   input  wire logic        twi_bypass_override_pin,  // low cancels twi bypass
   input  wire logic        uart_bypass_override_pin, // low cancels uart bypass
   input  wire logic [7:0]  security_config_byte_in,  // stored byte at boot
   input  wire logic        image_crc_bad_in,// stored crc state at boot
   output logic             do_twi_test,     // boot runs ack test
   output logic             do_uart_test,    // boot runs rx test
   output logic             error_output_pin,// serial error code out
   output logic             app_start_allowed,// image may run
   output logic             mem_we,          // memory write strobe
   output logic             mem_re,          // memory read strobe
   output logic [15:0]      mem_addr,        // memory address
   output logic [7:0]       mem_wdata,       // memory write data
   input  wire logic [7:0]  mem_rdata,       // read data, next cycle
   output logic             chip_erase,      // erase pulse
   output logic             jump_valid,      // jump pulse
   output logic [15:0]      jump_addr,       // jump target
   output logic [7:0]       security_config_byte // current security byte
);
   typedef enum {S_BAUD_IDLE, S_BAUD_MEAS, S_RUN} baud_t;
   typedef enum {P_MARK, P_HI, P_LO, P_EXEC, P_RD, P_RD2, P_WAIT} parse_t;

   baud_t       baud_state;
   parse_t      pst;
   logic        rx_m, rx_s, rx_d;
   logic [15:0] bit_cnt;          // measured bit time in mclk
   logic [15:0] rx_tmr;
   logic [3:0]  rx_bit;
   logic [7:0]  rx_sh;
   logic        rx_busy, rx_done;
   logic [7:0]  rx_byte;
   logic [3:0]  hi_nib;
   logic [6:0]  byte_idx;         // 0 len,1-2 off,3 type,4-67 data,68 sum
   logic [7:0]  sum;
   logic [15:0] offset;
   logic [7:0]  rtype;
   logic [7:0]  data [isp_pkg::DATA_BYTES];
   logic [7:0]  fifo_in;
   logic        fifo_push, fifo_rdy, fifo_vld, fifo_pop;
   logic [7:0]  fifo_out;
   logic [15:0] tx_tmr;
   logic [3:0]  tx_bit;
   logic [9:0]  tx_sh;
   logic        tx_busy;
   logic [15:0] crc;
   logic [6:0]  wr_idx;
   logic [15:0] rd_addr, rd_end;
   logic [1:0]  rd_mode;
   logic        blank_ok;
   logic [7:0]  err_sh;
   logic [3:0]  err_bit;
   logic [15:0] err_tmr;
   logic        err_go;

   function automatic logic [3:0] hex_val(input logic [7:0] c); // R10
      if (c >= 8'h30 && c <= 8'h39) return 4'(c - 8'h30);
      else if (c >= 8'h41 && c <= 8'h46) return 4'(c - 8'h37);
      else return 4'(c - 8'h57);
   endfunction : hex_val

   function automatic logic [7:0] hex_chr(input logic [3:0] n);
      return (n < 4'hA) ? 8'(n) + 8'h30 : 8'(n) + 8'h37;
   endfunction : hex_chr

   function automatic logic [15:0] crc_byte(input logic [15:0] w, input logic [7:0] b);
      logic [15:0] x;
      x = {8'h00, w[7:0] ^ b};
      for (int k = 0; k < 8; k++) begin
         x = x[0] ? ((x >> 1) ^ isp_pkg::CRC_POLY) : (x >> 1);
      end
      return x ^ (w >> 8);
   endfunction : crc_byte

   // boot bypass decisions
   assign do_twi_test  = security_config_byte[isp_pkg::BIT_TWI_BYPASS] || !twi_bypass_override_pin;   // R1 R3
   assign do_uart_test = security_config_byte[isp_pkg::BIT_UART_BYPASS] || !uart_bypass_override_pin; // R2 R3

   // pin synchroniser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_m <= 1'b1;
         rx_s <= 1'b1;
         rx_d <= 1'b1;
      end else begin
         rx_m <= rxd;
         rx_s <= rx_m;
         rx_d <= rx_s;
      end
   end

   // autobaud: U start bit low time is one bit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         baud_state <= S_BAUD_IDLE;
         bit_cnt    <= '0;
      end else begin
         case (baud_state)
            S_BAUD_IDLE: if (rx_d && !rx_s) begin
               bit_cnt    <= 16'h0001;
               baud_state <= S_BAUD_MEAS;
            end
            S_BAUD_MEAS: if (rx_s) begin
               baud_state <= (bit_cnt >= isp_pkg::BAUD_MIN) ? S_RUN : S_BAUD_IDLE; // R6
            end else begin
               bit_cnt <= bit_cnt + 16'h0001;
            end
            default: ;
         endcase
      end
   end

   // receiver, 8N1, sampled mid bit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_busy <= 1'b0;
         rx_done <= 1'b0;
         rx_tmr  <= '0;
         rx_bit  <= '0;
         rx_sh   <= '0;
         rx_byte <= '0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (baud_state == S_RUN && rx_d && !rx_s) begin
               rx_busy <= 1'b1;
               rx_tmr  <= bit_cnt >> 1;
               rx_bit  <= '0;
            end
         end else if (rx_tmr != 16'h0000) begin
            rx_tmr <= rx_tmr - 16'h0001;
         end else begin
            rx_tmr <= bit_cnt - 16'h0001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'd0 && rx_s) begin
               rx_busy <= 1'b0;          // false start
            end else if (rx_bit >= 4'd1 && rx_bit <= 4'd8) begin
               rx_sh <= {rx_s, rx_sh[7:1]}; // R5
            end else if (rx_bit == 4'd9) begin
               rx_busy <= 1'b0;
               rx_done <= rx_s;          // framing error drops char
               rx_byte <= rx_sh;
            end
         end
      end
   end

   // record parser and command executor
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pst <= P_MARK;
         hi_nib <= '0;
         byte_idx <= '0;
         sum <= '0;
         offset <= '0;
         rtype <= '0;
         fifo_push <= 1'b0;
         fifo_in <= '0;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= '0;
         chip_erase <= 1'b0;
         jump_valid <= 1'b0;
         jump_addr <= '0;
         security_config_byte <= isp_pkg::SSB_RESET;
         crc <= isp_pkg::CRC_INIT;
         wr_idx <= '0;
         rd_addr <= '0;
         rd_end <= '0;
         rd_mode <= '0;
         blank_ok <= 1'b1;
         app_start_allowed <= 1'b0;
         err_go <= 1'b0;
      end else begin
         mem_we     <= 1'b0;
         mem_re     <= 1'b0;
         chip_erase <= 1'b0;
         jump_valid <= 1'b0;
         fifo_push  <= 1'b0;
         err_go     <= 1'b0;
         if (fifo_push && !fifo_rdy) begin
            fifo_push <= 1'b1;             // hold until accepted
         end else begin
         case (pst)
            P_MARK: begin
               security_config_byte <= security_config_byte_in; // R4
               app_start_allowed    <= !image_crc_bad_in; // R19
               if (rx_done && rx_byte == isp_pkg::CH_COLON) begin // R7
                  pst      <= P_HI;
                  byte_idx <= '0;
                  sum      <= '0;
               end
            end
            P_HI: if (rx_done) begin
               hi_nib <= hex_val(rx_byte);
               pst    <= P_LO;
            end
            P_LO: if (rx_done) begin
               sum <= sum + {hi_nib, hex_val(rx_byte)}; // R11
               if (byte_idx == 7'd1) offset[15:8] <= {hi_nib, hex_val(rx_byte)}; // R9
               if (byte_idx == 7'd2) offset[7:0] <= {hi_nib, hex_val(rx_byte)};
               if (byte_idx == 7'd3) rtype <= {hi_nib, hex_val(rx_byte)};
               if (byte_idx >= 7'd4 && byte_idx < 7'd68) data[6'(byte_idx - 7'd4)] <= {hi_nib, hex_val(rx_byte)};
               byte_idx <= byte_idx + 7'd1;
               pst      <= (byte_idx == 7'd68) ? P_EXEC : P_HI; // R8
               wr_idx   <= '0;
            end
            P_EXEC: begin
               pst <= P_WAIT;
               if (sum != 8'h00) begin
                  fifo_in   <= isp_pkg::CH_X;   // R17
                  fifo_push <= 1'b1;
               end else if (rtype == isp_pkg::T_PROG) begin // R12
                  if (security_config_byte[isp_pkg::BIT_WR_LOCK] == 1'b0) begin
                     pst <= P_MARK;             // R21
                  end else begin
                     pst       <= P_RD;
                  end
               end else if (rtype == isp_pkg::T_EOF) begin
                  pst <= P_MARK;
               end else if (rtype == isp_pkg::T_WRITE) begin // R13
                  if (data[0] == isp_pkg::F_ERASE) begin
                     chip_erase           <= 1'b1;
                     security_config_byte <= isp_pkg::SSB_LEVEL0; // R24
                     crc                  <= isp_pkg::CRC_INIT;
                  end else if (data[0] == isp_pkg::F_SSB && data[1] == 8'h00 && security_config_byte[isp_pkg::BIT_RD_LOCK]) begin
                     security_config_byte[isp_pkg::BIT_WR_LOCK] <= 1'b0; // R23 R24
                  end else if (data[0] == isp_pkg::F_SSB && data[1] == 8'h01) begin
                     security_config_byte[1:0] <= 2'b00;
                  end else if (data[0] == isp_pkg::F_JUMP) begin
                     jump_addr  <= {data[2], data[3]};
                     jump_valid <= app_start_allowed;
                  end
               end else if (rtype == isp_pkg::T_DISPLAY) begin // R14
                  if (security_config_byte[isp_pkg::BIT_RD_LOCK] == 1'b0) begin
                     pst <= P_MARK;             // R20
                  end else begin
                     rd_addr  <= {data[0], data[1]};
                     rd_end   <= {data[2], data[3]};
                     rd_mode  <= data[4][1:0];
                     blank_ok <= 1'b1;
                     pst      <= P_RD2;
                  end
               end else if (rtype == isp_pkg::T_READ) begin // R15
                  fifo_in   <= (data[0] == isp_pkg::F_RD_VER) ? isp_pkg::LOADER_VERSION : security_config_byte;
                  fifo_push <= (data[0] == isp_pkg::F_RD_VER || data[0] == isp_pkg::F_RD_SSB);
               end else begin
                  pst <= P_MARK;                // R16 R25
               end
            end
            P_RD: begin
               // program: one byte per cycle, crc kept over the image
               mem_we    <= 1'b1;
               mem_addr  <= (offset + 16'(wr_idx)) & isp_pkg::ADDR_MASK;
               mem_wdata <= data[6'(wr_idx)];
               crc       <= crc_byte(crc, data[6'(wr_idx)]);
               wr_idx    <= wr_idx + 7'd1;
               if (wr_idx == 7'(isp_pkg::DATA_BYTES - 1)) begin
                  pst <= P_WAIT;
                  if (((offset + 16'(wr_idx)) & isp_pkg::ADDR_MASK) == isp_pkg::LAST_ADDR) begin
                     if (crc_byte(crc, data[6'(wr_idx)]) == isp_pkg::CRC_REF) begin
                        fifo_in <= isp_pkg::CH_Y;
                     end else begin
                        fifo_in           <= isp_pkg::CH_Z; // R18
                        err_go            <= 1'b1;
                        app_start_allowed <= 1'b0;         // R19
                     end
                     fifo_push <= 1'b1;
                     crc       <= isp_pkg::CRC_INIT;
                  end else begin
                     fifo_in   <= isp_pkg::CH_DOT;
                     fifo_push <= 1'b1;
                  end
               end
            end
            P_RD2: begin
               // display: request, emit high hex char of prior data, at rd_end the low char in its place
               mem_re   <= 1'b1;
               mem_addr <= rd_addr;
               if (mem_re) begin
                  if (rd_mode == isp_pkg::D_BLANK[1:0]) begin
                     blank_ok <= blank_ok && (mem_rdata == 8'hFF);
                  end else begin
                     fifo_in   <= hex_chr(mem_rdata[7:4]);
                     fifo_push <= 1'b1;
                  end
                  mem_re <= 1'b0;
                  if (mem_addr == rd_end) begin
                     pst       <= P_WAIT;
                     fifo_in   <= (rd_mode == isp_pkg::D_BLANK[1:0]) ? (blank_ok && mem_rdata == 8'hFF ? isp_pkg::CH_Y : isp_pkg::CH_X) : hex_chr(mem_rdata[3:0]);
                     fifo_push <= 1'b1;
                  end else begin
                     rd_addr <= rd_addr + 16'h0001;
                  end
               end
            end
            default: begin
               fifo_in   <= isp_pkg::CH_CR;
               fifo_push <= 1'b1;
               pst       <= P_MARK;
            end
         endcase
         end
      end
   end

   // answer queue
   isp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_data   (fifo_in),
      .in_valid  (fifo_push),
      .in_ready  (fifo_rdy),
      .out_data  (fifo_out),
      .out_valid (fifo_vld),
      .out_ready (fifo_pop)
   );
   assign fifo_pop = fifo_vld && !tx_busy && (baud_state == S_RUN);

   // transmitter 8N1 at measured rate
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_busy <= 1'b0;
         tx_sh   <= '1;
         tx_tmr  <= '0;
         tx_bit  <= '0;
         txd     <= 1'b1;
      end else if (!tx_busy) begin
         txd <= 1'b1;
         if (fifo_pop) begin
            tx_busy <= 1'b1;
            tx_sh   <= {1'b1, fifo_out, 1'b0}; // R5
            tx_tmr  <= '0;
            tx_bit  <= '0;
         end
      end else if (tx_tmr != 16'h0000) begin
         tx_tmr <= tx_tmr - 16'h0001;
      end else if (tx_bit == 4'd10) begin
         tx_busy <= 1'b0;
      end else begin
         txd    <= tx_sh[0];
         tx_sh  <= {1'b1, tx_sh[9:1]};
         tx_bit <= tx_bit + 4'h1;
         tx_tmr <= bit_cnt - 16'h0001;
      end
   end

   // error code shifter on error pin, idle high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         err_sh           <= '0;
         err_bit          <= '0;
         err_tmr          <= '0;
         error_output_pin <= 1'b1;
      end else if (err_go) begin
         err_sh  <= isp_pkg::ERR_CODE; // R18
         err_bit <= 4'd8;
         err_tmr <= '0;
      end else if (err_bit != 4'd0) begin
         if (err_tmr != 16'h0000) begin
            err_tmr <= err_tmr - 16'h0001;
         end else begin
            error_output_pin <= err_sh[0];
            err_sh           <= err_sh >> 1;
            err_bit          <= err_bit - 4'd1;
            err_tmr          <= bit_cnt;
         end
      end else if (err_tmr != 16'h0000) begin
         err_tmr <= err_tmr - 16'h0001;
      end else begin
         error_output_pin <= 1'b1;
      end
   end
endmodule : isp_hex_record_interpreter

// ---- isp_hex_record_interpreter_props.sv ----
// port checker for the hex record interpreter
// assumes one clock domain, bound from the bench top
`timescale 1ns/10ps
module isp_hex_record_interpreter_props (
   input wire logic        mclk,                     // clock
   input wire logic        rst_n,                    // reset
   input wire logic        twi_bypass_override_pin,  // pin
   input wire logic        uart_bypass_override_pin, // pin
   input wire logic        image_crc_bad_in,         // crc
   input wire logic        do_twi_test,              // out
   input wire logic        do_uart_test,             // out
   input wire logic        app_start_allowed,        // out
   input wire logic        mem_we,                   // out
   input wire logic [15:0] mem_addr,                 // out
   input wire logic        chip_erase,               // out
   input wire logic        jump_valid,               // out
   input wire logic [7:0]  security_config_byte      // out
);
   logic [7:0] run;
   // length of the current write burst
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n) run <= 8'h00;
      else run <= mem_we ? run + 8'h01 : 8'h00;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_erase; chip_erase ##1 !chip_erase; endsequence
   chk_twi_test: assert property (do_twi_test == (security_config_byte[7] | !twi_bypass_override_pin))
      else $error("twi test enable wrong");
   chk_uart_test: assert property (do_uart_test == (security_config_byte[6] | !uart_bypass_override_pin))
      else $error("uart test enable wrong");
   chk_crc_block: assert property (image_crc_bad_in |-> ##[1:2] !app_start_allowed)
      else $error("start allowed after bad crc");
   chk_burst_len: assert property ($fell(mem_we) |-> run == 8'h40)
      else $error("write burst not 64");
   chk_addr_step: assert property (mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 16'h0001)
      else $error("write address not stepping");
   chk_write_lock: assert property (mem_we |-> security_config_byte[0])
      else $error("write while locked");
   chk_erase_pulse: assert property (chip_erase |-> s_erase)
      else $error("erase not one cycle");
   chk_jump_gate: assert property (jump_valid |-> app_start_allowed)
      else $error("jump without start");
endmodule : isp_hex_record_interpreter_props

// ---- isp_host_model.sv ----
// host side: sends 8n1 hex records, collects answer characters
// assumes a fixed bit time of BIT_CYC clocks
`timescale 1ns/10ps
module isp_host_model #(
   parameter int BIT_CYC = 8
) (
   input  wire logic mclk, // clock
   output logic      rxd,  // to device
   input  wire logic txd   // from device
);
   logic [7:0] rx_q[$];
   // start bit, lsb first, one stop bit
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
         repeat (BIT_CYC) @(posedge mclk);
      end
   endtask : send_byte
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction : hx
   // colon, then 69 bytes as hex pairs
   task automatic send_rec(input logic [7:0] t, input logic [15:0] o, input logic [7:0] d[64], input logic bad);
      logic [7:0] s, b;
      s = 8'h00;
      send_byte(isp_pkg::CH_COLON);
      for (int i = 0; i < 69; i++) begin
         b = (i == 0) ? isp_pkg::REC_LEN : (i == 1) ? o[15:8] : (i == 2) ? o[7:0] : (i == 3) ? t
            : (i < 68) ? d[i - 4] : (8'h00 - s) ^ {7'h00, bad};
         s = s + b;
         send_byte(hx(b[7:4]));
         send_byte(hx(b[3:0]));
      end
   endtask : send_rec
   // answer receiver, samples mid-bit
   initial begin
      logic [7:0] c;
      rxd = 1'b1;
      forever begin
         @(negedge txd);
         repeat (BIT_CYC / 2) @(posedge mclk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            c[i] = txd;
         end
         rx_q.push_back(c);
      end
   end
endmodule : isp_host_model

// ---- isp_pkg.sv ----
// constants shared by the hex-record programming interpreter
// assumes a single mclk domain at 20 MHz and no register bus
package isp_pkg;
   localparam int          CLK_HZ           = 20_000_000;
   localparam logic [7:0]  CH_COLON         = 8'h3A;
   localparam logic [7:0]  CH_U             = 8'h55;
   localparam logic [7:0]  CH_X             = 8'h58;
   localparam logic [7:0]  CH_Y             = 8'h59;
   localparam logic [7:0]  CH_Z             = 8'h5A;
   localparam logic [7:0]  CH_DOT           = 8'h2E;
   localparam logic [7:0]  CH_CR            = 8'h0D;
   localparam logic [7:0]  REC_LEN          = 8'h40;
   localparam int          DATA_BYTES       = 64;
   localparam logic [7:0]  T_PROG           = 8'h00;
   localparam logic [7:0]  T_EOF            = 8'h01;
   localparam logic [7:0]  T_WRITE          = 8'h03;
   localparam logic [7:0]  T_DISPLAY        = 8'h04;
   localparam logic [7:0]  T_READ           = 8'h05;
   localparam logic [7:0]  T_BAUD           = 8'h06;
   localparam logic [7:0]  F_ERASE          = 8'h07;
   localparam logic [7:0]  F_SSB            = 8'h05;
   localparam logic [7:0]  F_JUMP           = 8'h03;
   localparam logic [7:0]  F_RD_SSB         = 8'h07;
   localparam logic [7:0]  F_RD_VER         = 8'h0F;
   localparam logic [7:0]  D_DATA           = 8'h00;
   localparam logic [7:0]  D_BLANK          = 8'h01;
   localparam logic [7:0]  D_CODE_RAM           = 8'h03;
   localparam logic [7:0]  SSB_LEVEL0       = 8'hFF;
   localparam logic [7:0]  SSB_RESET        = 8'hFF;
   localparam int          BIT_TWI_BYPASS   = 7;
   localparam int          BIT_UART_BYPASS  = 6;
   localparam int          BIT_WR_LOCK      = 0;
   localparam int          BIT_RD_LOCK      = 1;
   localparam logic [7:0]  ERR_CODE         = 8'hAA;
   localparam logic [15:0] CRC_INIT         = 16'hFFFF;
   localparam logic [15:0] CRC_POLY         = 16'h8408;
   localparam logic [15:0] CRC_REF          = 16'hF0B8;
   localparam logic [15:0] LAST_ADDR        = 16'h3FFF;
   localparam logic [15:0] ADDR_MASK        = 16'h3FFF;
   localparam logic [15:0] BAUD_MIN         = 16'h0004;
   localparam logic [7:0]  LOADER_VERSION   = 8'h10; // arbitrary value
endpackage : isp_pkg

// ---- test_isp_hex_record_interpreter.sv ----
// self-checking bench for the hex record interpreter
// assumes the host model on the serial pins
`timescale 1ns/10ps
module test_isp_hex_record_interpreter;
   logic        mclk, rst_n, rxd, txd, twi_p, uart_p, crc_bad, we, erase, dtw, dua, app;
   logic [7:0]  sb_in, wdata, sb, d[64];
   logic [15:0] addr;
   int          n_fail, cmp_count, n_we, n_er, seed;
   logic [7:0]  vals[12] = '{8'hFF, 8'hFE, 8'hFC, 8'hBF, 8'hBE, 8'hBC, 8'h7F, 8'h7E, 8'h7C, 8'h3F, 8'h3E, 8'h3C};
   isp_hex_record_interpreter i_dut (.mclk(mclk), .rst_n(rst_n), .rxd(rxd), .txd(txd), .twi_bypass_override_pin(twi_p),
      .uart_bypass_override_pin(uart_p), .security_config_byte_in(sb_in), .image_crc_bad_in(crc_bad),
      .do_twi_test(dtw), .do_uart_test(dua), .error_output_pin(), .app_start_allowed(app), .mem_we(we), .mem_re(),
      .mem_addr(addr), .mem_wdata(wdata), .mem_rdata(8'h00), .chip_erase(erase), .jump_valid(), .jump_addr(),
      .security_config_byte(sb));
   isp_host_model #(.BIT_CYC(8)) i_host (.mclk(mclk), .rxd(rxd), .txd(txd));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("mismatches %0d of %0d compares", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic rst(input logic [7:0] v);
      @(negedge mclk);
      sb_in = v;
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      i_host.send_byte(isp_pkg::CH_U);
      repeat (150) @(negedge mclk);
   endtask : rst
   task automatic expect_rx(input logic [7:0] a, input logic [7:0] b);
      for (int k = 0; k < 3000 && i_host.rx_q.size() < 2; k++) @(negedge mclk);
      check(i_host.rx_q.size(), 2);
      check(i_host.rx_q.pop_front(), a);
      check(i_host.rx_q.pop_front(), b);
   endtask : expect_rx
   // write strobes against the record, erase pulses counted
   always @(negedge mclk) begin
      if (we) begin
         check(addr, 16'h0040 + n_we[15:0]);
         check(wdata, d[n_we]);
         n_we++;
      end
      if (erase) n_er++;
   end
   initial begin
      #4500000;
      n_fail++;
      final_report();
   end
   initial begin
      {seed, n_fail, cmp_count, n_we, n_er} = {32'd57752, 128'd0};
      {twi_p, uart_p, crc_bad, rst_n, sb_in} = {4'h0, 8'hFF};
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      check(sb, isp_pkg::SSB_RESET);
      check(app, 1'b0);
      // every valid byte with random override levels
      for (int i = 0; i < 24; i++) begin
         {twi_p, uart_p} = 2'($random(seed));
         rst(vals[i % 12]);
         check(sb, sb_in);
         check(dtw, sb_in[7] | !twi_p);
         check(dua, sb_in[6] | !uart_p);
      end
      crc_bad = 1'b1;
      repeat (2) @(negedge mclk);
      check(app, 1'b0);
      crc_bad = 1'b0;
      rst(8'hFF);
      for (int i = 0; i < 64; i++) d[i] = 8'($random(seed));
      i_host.send_rec(isp_pkg::T_PROG, 16'h0040, d, 1'b0);
      expect_rx(isp_pkg::CH_DOT, isp_pkg::CH_CR);
      check(n_we, 64);
      // bad checksum, then security byte and version reads
      d[1] = 8'h00;
      for (int j = 0; j < 3; j++) begin
         d[0] = (j == 2) ? isp_pkg::F_RD_VER : isp_pkg::F_RD_SSB;
         i_host.send_rec(isp_pkg::T_READ, 16'h0000, d, j == 0);
         expect_rx((j == 0) ? isp_pkg::CH_X : (j == 1) ? 8'hFF : isp_pkg::LOADER_VERSION, isp_pkg::CH_CR);
      end
      // write lock refuses programming, erase still taken
      rst(8'hFE);
      i_host.send_rec(isp_pkg::T_PROG, 16'h0000, d, 1'b0);
      repeat (1000) @(negedge mclk);
      check(i_host.rx_q.size(), 0);
      check(n_we, 64);
      d[0] = isp_pkg::F_ERASE;
      i_host.send_rec(isp_pkg::T_WRITE, 16'h0000, d, 1'b0);
      for (int k = 0; k < 3000 && n_er == 0; k++) @(negedge mclk);
      check(n_er, 1);
      final_report();
   end
endmodule : test_isp_hex_record_interpreter
bind isp_hex_record_interpreter isp_hex_record_interpreter_props i_props (.*);
